// file: hw/adgc_top.sv
// digital i/o, external start trigger and gate line control
//
// Contract
// R1 - status mode: output per module high while it acquires, pins 0..3
// R2 - invert flips the polarity of the status indication
// R3 - value mode: an 8-bit value 0..255 appears on the port
// R4 - value mode: the value steps by one at each acquisition stop; code steps once when several systems stop in one cycle
// R5 - invert flips every bit of the shown value
// R6 - pins drive push-pull, or open drain (low only) by selection
// R7 - trigger input 4 starts system 1; inputs 4..7 serve systems 1..4
// R8 - with trigger enabled, start only arms and watches the input level
// R9 - while watching, a falling input clears data then starts acquisition; code clears only with the R12 option (bit 11) set
// R10 - input back high stops, next fall restarts; invert swaps levels
// R11 - a stop command ends watching of that system's trigger
// R12 - clear-before-start option erases data before triggered start
// R13 - gate line enables hardware; watch, high-at-start, low-at-stop
// R14 - low-at-stop pulls the gate line low when sweep preset is hit
// R15 - modules group into at most four systems, commanded as a unit
// R16 - control bits 0..3: status, value, invert, push-pull
// R17 - control bits 8..11: watch, high at start, low at stop, clear
// R18 - high-at-start releases the gate line high when a start takes effect
`include "adgc_map.svh"
module adgc_top
    import adgc_pkg::*;
#(
    parameter int N_MOD = `ADGC_MAX_MOD,
    parameter int N_SYS = `ADGC_MAX_SYS
)(
    input  wire logic                                  CLK_SYS,
    input  wire logic                                  RESET,
    input  wire logic [`ADGC_CW_W-1:0]                 CTRL_WORD,
    input  wire logic [`ADGC_DIO_W-1:0]                VALUE_IN,
    input  wire logic                                  VALUE_LOAD,
    input  wire logic [N_MOD-1:0]                      MOD_EN,
    input  wire logic [N_MOD-1:0][`ADGC_SYS_IDX_W-1:0] MOD_SYS,
    input  wire logic [N_SYS-1:0]                      START_CMD,
    input  wire logic [N_SYS-1:0]                      STOP_CMD,
    input  wire logic [N_MOD-1:0]                      SWEEP_HIT,
    input  wire logic [`ADGC_DIO_W-1:0]                DIG_IN,
    input  wire logic                                  GATE_IN,
    output logic      [`ADGC_DIO_W-1:0]                DIG_OUT,
    output logic      [`ADGC_DIO_W-1:0]                DIG_OE_N,
    output logic                                       GATE_OUT,
    output logic                                       GATE_OE_N,
    output logic      [N_MOD-1:0]                      ACQ_ENABLE,
    output logic      [N_MOD-1:0]                      ACQ_RUNNING,
    output logic      [N_SYS-1:0]                      CLEAR_DATA,
    output logic      [`ADGC_DIO_W-1:0]                VALUE_OUT
);
    // refuse sizes that the index and trigger pin widths cannot serve
    if (N_MOD < 1 || N_MOD > `ADGC_MAX_MOD ||
        N_SYS < 1 || N_SYS > `ADGC_MAX_SYS)
    begin : g_bad_size
        $error("adgc_top: module or system count out of range");
    end

    adgc_ctrl_s                      ctrl;
    logic [`ADGC_DIO_W-1:0]          din_s1_r;
    logic [`ADGC_DIO_W-1:0]          din_s2_r;
    logic [`ADGC_DIO_W-1:0]          din_d_r;
    logic                            gate_s1_r;
    logic                            gate_s2_r;
    adgc_state_e                     st_r      [N_SYS];
    adgc_state_e                     st_nxt    [N_SYS];
    logic [N_SYS-1:0]                clr_r;
    logic [N_SYS-1:0]                clr_nxt;
    logic [N_SYS-1:0]                sys_run;
    logic [N_SYS-1:0]                sys_hit;
    logic [N_SYS-1:0]                act_now;
    logic [N_SYS-1:0]                act_edge;
    logic [N_SYS-1:0]                start_evt;
    logic [N_SYS-1:0]                stop_evt;
    logic [N_MOD-1:0]                mod_run;
    logic [N_MOD-1:0]                run_r;
    logic [N_MOD-1:0]                en_r;
    logic [N_MOD-1:0]                en_nxt;
    logic [`ADGC_DIO_W-1:0]          value_r;
    logic [`ADGC_DIO_W-1:0]          value_nxt;
    logic [`ADGC_DIO_W-1:0]          dout_r;
    logic [`ADGC_DIO_W-1:0]          dout_nxt;
    logic [`ADGC_DIO_W-1:0]          oe_n_r;
    logic [`ADGC_DIO_W-1:0]          oe_n_nxt;
    logic                            gate_r;
    logic                            gate_nxt;

    // control word decode into named enables
    assign ctrl.status     = CTRL_WORD[`ADGC_CW_STATUS];       // see R16
    assign ctrl.value      = CTRL_WORD[`ADGC_CW_VALUE];        // see R16
    assign ctrl.invert     = CTRL_WORD[`ADGC_CW_INVERT];       // see R16
    assign ctrl.pushpull   = CTRL_WORD[`ADGC_CW_PUSHPULL];     // see R16
    assign ctrl.trig_en    = CTRL_WORD[`ADGC_CW_TRIG_HI:`ADGC_CW_TRIG_LO];
    assign ctrl.gate_watch = CTRL_WORD[`ADGC_CW_GWATCH];       // see R17
    assign ctrl.gate_high  = CTRL_WORD[`ADGC_CW_GHIGH];        // see R17
    assign ctrl.gate_low   = CTRL_WORD[`ADGC_CW_GLOW];         // see R17
    assign ctrl.clr_start  = CTRL_WORD[`ADGC_CW_CLRSTART];     // see R17

    // pins are asynchronous: two stages, then a delayed copy for edges
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            din_s1_r  <= `ADGC_DIN_RST;    // pulled-up idle, no false edge
            din_s2_r  <= `ADGC_DIN_RST;
            din_d_r   <= `ADGC_DIN_RST;
            gate_s1_r <= 1'b1;
            gate_s2_r <= 1'b1;
        end
        else
        begin
            din_s1_r  <= DIG_IN;
            din_s2_r  <= din_s1_r;
            din_d_r   <= din_s2_r;
            gate_s1_r <= GATE_IN;
            gate_s2_r <= gate_s1_r;
        end
    end

    genvar s;
    genvar m;
    generate
        // one start/watch/run sequencer per system
        for (s = 0; s < N_SYS; s++)
        begin : g_sys
            logic [N_MOD-1:0] memb;
            for (m = 0; m < N_MOD; m++)
            begin : g_memb
                assign memb[m] = MOD_EN[m] &&
                    (MOD_SYS[m] == `ADGC_SYS_IDX_W'(s));   // see R15
            end
            assign sys_hit[s] = |(SWEEP_HIT & memb);
            // active level is low, or high when inverted
            assign act_now[s] = din_s2_r[`ADGC_TRIG_PIN0 + s]
                                ^ ~ctrl.invert;             // see R7, R10
            assign act_edge[s] = act_now[s] &
                (din_d_r[`ADGC_TRIG_PIN0 + s] ^ ctrl.invert); // see R9
            assign sys_run[s] = (st_r[s] == ADGC_RUN) ||
                                (st_r[s] == ADGC_RUN_EXT);
            assign start_evt[s] = !sys_run[s] &&
                ((st_nxt[s] == ADGC_RUN) || (st_nxt[s] == ADGC_RUN_EXT));
            assign stop_evt[s] = sys_run[s] &&
                (st_nxt[s] != ADGC_RUN) && (st_nxt[s] != ADGC_RUN_EXT);

            // stop command wins over start and trigger in the same cycle
            always_comb
            begin
                st_nxt[s]  = st_r[s];
                clr_nxt[s] = 1'b0;
                if (STOP_CMD[s])
                    st_nxt[s] = ADGC_IDLE;                  // see R11
                else
                begin
                    case (st_r[s])
                        ADGC_IDLE:
                        begin
                            if (START_CMD[s] && ctrl.trig_en[s])
                                st_nxt[s] = ADGC_ARMED;     // see R8
                            else if (START_CMD[s])
                            begin
                                st_nxt[s]  = ADGC_RUN;
                                clr_nxt[s] = 1'b1;
                            end
                        end
                        ADGC_ARMED:
                        begin
                            if (!ctrl.trig_en[s])
                                st_nxt[s] = ADGC_IDLE;
                            else if (act_edge[s] && !sys_hit[s])
                            begin
                                st_nxt[s]  = ADGC_RUN_EXT;  // see R9
                                clr_nxt[s] = ctrl.clr_start; // see R12
                            end
                        end
                        ADGC_RUN_EXT:
                        begin
                            if (sys_hit[s])
                                st_nxt[s] = ADGC_IDLE;
                            else if (!act_now[s])
                                st_nxt[s] = ADGC_ARMED;     // see R10
                        end
                        ADGC_RUN:
                        begin
                            if (sys_hit[s])
                                st_nxt[s] = ADGC_IDLE;
                        end
                        default:
                            st_nxt[s] = ADGC_IDLE;
                    endcase
                end
            end

            always_ff @(posedge CLK_SYS or posedge RESET)
            begin
                if (RESET)
                begin
                    st_r[s]  <= ADGC_IDLE;
                    clr_r[s] <= 1'b0;
                end
                else
                begin
                    st_r[s]  <= st_nxt[s];
                    clr_r[s] <= clr_nxt[s];
                end
            end
        end

        // each module follows the system it belongs to
        for (m = 0; m < N_MOD; m++)
        begin : g_mod
            assign mod_run[m] = MOD_EN[m] && sys_run[MOD_SYS[m]]; // see R15
        end
    endgenerate

    // value counter, pins, gate line and hardware enables
    always_comb
    begin
        value_nxt = value_r;
        if (VALUE_LOAD)
            value_nxt = VALUE_IN;
        else if (ctrl.value && |stop_evt)
            value_nxt = value_r + `ADGC_VALUE_STEP;         // see R4
        dout_nxt = `ADGC_DIO_RST;
        oe_n_nxt = `ADGC_OE_N_RST;
        if (ctrl.value)
        begin
            dout_nxt = value_r ^ {`ADGC_DIO_W{ctrl.invert}}; // see R3, R5
            oe_n_nxt = ~`ADGC_OE_N_RST;
        end
        else if (ctrl.status)
        begin
            dout_nxt[N_MOD-1:0] = mod_run
                                ^ {N_MOD{ctrl.invert}};     // see R1, R2
            oe_n_nxt[N_MOD-1:0] = '0;
        end
        // pins of enabled triggers are inputs and are never driven
        oe_n_nxt[`ADGC_CW_TRIG_HI:`ADGC_TRIG_PIN0] =
            oe_n_nxt[`ADGC_CW_TRIG_HI:`ADGC_TRIG_PIN0]
            | ctrl.trig_en;                                 // see R7
        // open drain only sinks: a high bit is released to the pull-up
        if (!ctrl.pushpull)
        begin
            oe_n_nxt = oe_n_nxt | dout_nxt;                 // see R6
            dout_nxt = `ADGC_DIO_RST;
        end
        // low at stop has priority over high at start
        gate_nxt = gate_r;
        if (ctrl.gate_low && |SWEEP_HIT)
            gate_nxt = 1'b0;                                // see R14
        else if (ctrl.gate_high && |start_evt)
            gate_nxt = 1'b1;                                // see R18
        for (int k = 0; k < N_MOD; k++)
            en_nxt[k] = mod_run[k] &&
                (!ctrl.gate_watch || gate_s2_r);            // see R13
    end

    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            value_r <= `ADGC_VALUE_RST;
            dout_r  <= `ADGC_DIO_RST;
            oe_n_r  <= `ADGC_OE_N_RST;
            gate_r  <= 1'b1;
            run_r   <= '0;
            en_r    <= '0;
        end
        else
        begin
            value_r <= value_nxt;
            dout_r  <= dout_nxt;
            oe_n_r  <= oe_n_nxt;
            gate_r  <= gate_nxt;
            run_r   <= mod_run;
            en_r    <= en_nxt;
        end
    end

    assign DIG_OUT     = dout_r;
    assign DIG_OE_N    = oe_n_r;
    assign GATE_OUT    = 1'b0;      // gate is open drain: low or released
    assign GATE_OE_N   = gate_r;
    assign ACQ_ENABLE  = en_r;
    assign ACQ_RUNNING = run_r;
    assign CLEAR_DATA  = clr_r;
    assign VALUE_OUT   = value_r;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    a_status_pin_zero: assert property (                    // see R1, R2
        ctrl.status && !ctrl.value && ctrl.pushpull
        |=> DIG_OUT[0] == ($past(mod_run[0]) ^ $past(ctrl.invert)))
        else $error("status pin does not follow module run");

    a_value_on_port: assert property (                      // see R3, R5
        ctrl.value && ctrl.pushpull && ctrl.trig_en == '0
        |=> DIG_OUT == ($past(value_r) ^ {`ADGC_DIO_W{$past(ctrl.invert)}}))
        else $error("value not shown on port");

    a_value_step_one: assert property (                     // see R4
        !VALUE_LOAD && ctrl.value && |stop_evt
        |=> value_r == $past(value_r) + `ADGC_VALUE_STEP)
        else $error("value did not step at stop");

    a_open_drain_low: assert property (                     // see R6
        !ctrl.pushpull |=> DIG_OUT == 8'h00)
        else $error("open drain pin driven high");

    a_trig_arms_only: assert property (                     // see R8
        st_r[0] == ADGC_IDLE && START_CMD[0] && !STOP_CMD[0]
        && ctrl.trig_en[0] |=> st_r[0] == ADGC_ARMED ##1 !sys_run[0])
        else $error("triggered start did not arm");

    a_edge_start_run: assert property (                     // see R9, R12
        st_r[0] == ADGC_ARMED && ctrl.trig_en[0] && act_edge[0]
        && !STOP_CMD[0] && !sys_hit[0]
        |=> st_r[0] == ADGC_RUN_EXT && CLEAR_DATA[0] == $past(ctrl.clr_start))
        else $error("trigger edge did not start");

    a_release_rearm: assert property (                      // see R10
        st_r[0] == ADGC_RUN_EXT && !act_now[0] && !STOP_CMD[0]
        && !sys_hit[0] |=> st_r[0] == ADGC_ARMED)
        else $error("trigger release did not stop");

    a_stop_ends_watch: assert property (                    // see R11
        STOP_CMD[0] |=> st_r[0] == ADGC_IDLE && !sys_run[0])
        else $error("stop command did not end watching");

    a_gate_low_hit: assert property (                       // see R14
        ctrl.gate_low && |SWEEP_HIT |=> !GATE_OE_N)
        else $error("gate not pulled low at sweep preset");

    a_gate_high_start: assert property (                    // see R18
        ctrl.gate_high && |start_evt && !(ctrl.gate_low && |SWEEP_HIT)
        |=> GATE_OE_N)
        else $error("gate not released at start");
endmodule

// file: hw/adgc_map.svh
// bit positions, widths and reset values of the digital i/o gate block
`ifndef ADGC_MAP_SVH
`define ADGC_MAP_SVH
`define ADGC_CW_W        12
`define ADGC_CW_STATUS   0
`define ADGC_CW_VALUE    1
`define ADGC_CW_INVERT   2
`define ADGC_CW_PUSHPULL 3
`define ADGC_CW_TRIG_LO  4
`define ADGC_CW_TRIG_HI  7
`define ADGC_CW_GWATCH   8
`define ADGC_CW_GHIGH    9
`define ADGC_CW_GLOW     10
`define ADGC_CW_CLRSTART 11
`define ADGC_DIO_W       8
`define ADGC_TRIG_PIN0   4
`define ADGC_MAX_SYS     4
`define ADGC_MAX_MOD     4
`define ADGC_SYS_IDX_W   2
`define ADGC_VALUE_RST   8'h00
`define ADGC_VALUE_STEP  8'h01
`define ADGC_DIO_RST     8'h00
`define ADGC_DIN_RST     8'hFF
`define ADGC_OE_N_RST    8'hFF
`endif

// file: hw/adgc_pkg.sv
// types shared by the digital i/o gate block
package adgc_pkg;
    // per-system sequencing of start, trigger watch and run
    typedef enum logic [1:0] {
        ADGC_IDLE,
        ADGC_ARMED,
        ADGC_RUN_EXT,
        ADGC_RUN
    } adgc_state_e;

    // decoded i/o control word
    typedef struct packed {
        logic       clr_start;
        logic       gate_low;
        logic       gate_high;
        logic       gate_watch;
        logic [3:0] trig_en;
        logic       pushpull;
        logic       invert;
        logic       value;
        logic       status;
    } adgc_ctrl_s;
endpackage

// file: test/adgc_pins_model.sv
// pin side model: pull-ups, sample changer lines and trigger source
module adgc_pins_model
    import adgc_pkg::*;
(
    input  wire logic [7:0] dig_out,
    input  wire logic [7:0] dig_oe_n,
    input  wire logic       gate_oe_n,
    input  wire logic       gate_out,
    input  wire logic [3:0] trig_pull,
    output logic      [7:0] dig_pin,
    output logic            gate_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ext_low;

    // trigger source sits on pins 4..7 and can only pull low
    assign ext_low = {trig_pull, 4'h0};

    // released lines float up; any low driver wins the wire
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            dig_pin[i] = !((!dig_oe_n[i] && !dig_out[i]) || ext_low[i]);
        gate_pin = gate_oe_n || gate_out;
    end
endmodule

// file: test/adgc_top_tb.sv
// self-checking bench of the digital i/o and gate block
`include "adgc_map.svh"
module adgc_top_tb_top
    import adgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] run;
        logic [7:0] val;
        logic [7:0] pins;
        logic [7:0] mask;
        logic       gate;
        logic [15:0] clr;
        logic [3:0]  gen;
    } adgc_note_s;
    logic            clk_sys, reset, value_load, gate_in, gate_out, gate_oe_n;
    logic [11:0]     ctrl_word;
    logic [7:0]      value_in, dig_out, dig_oe_n, value_out, dig_pin, v;
    logic [3:0]      mod_en, start_cmd, stop_cmd, sweep_hit, trig_pull;
    logic [3:0]      acq_enable, acq_running, clear_data;
    logic [3:0][1:0] mod_sys;
    logic [15:0]     lfsr, clr_cnt, clr_base = 16'h0000;
    int              failures, compares;
    adgc_note_s      notes[$];
    adgc_note_s      n;
    event            seen;

    adgc_top i_adgc_top (.CLK_SYS(clk_sys), .RESET(reset),
        .CTRL_WORD(ctrl_word), .VALUE_IN(value_in), .VALUE_LOAD(value_load),
        .MOD_EN(mod_en), .MOD_SYS(mod_sys), .START_CMD(start_cmd),
        .STOP_CMD(stop_cmd), .SWEEP_HIT(sweep_hit), .DIG_IN(dig_pin),
        .GATE_IN(gate_in), .DIG_OUT(dig_out), .DIG_OE_N(dig_oe_n),
        .GATE_OUT(gate_out), .GATE_OE_N(gate_oe_n), .ACQ_ENABLE(acq_enable),
        .ACQ_RUNNING(acq_running), .CLEAR_DATA(clear_data),
        .VALUE_OUT(value_out));
    adgc_pins_model i_adgc_pins_model (.dig_out(dig_out),
        .dig_oe_n(dig_oe_n), .gate_oe_n(gate_oe_n), .gate_out(gate_out),
        .trig_pull(trig_pull),
        .dig_pin(dig_pin), .gate_pin(gate_in));

    // free running system clock, 50 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // clear pulses are one cycle, so they are tallied as they happen
    always @(posedge clk_sys)
        clr_cnt <= reset ? 16'h0000 : clr_cnt + 16'($countones(clear_data));

    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(logic [15:0] got, logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(int k);
        repeat (k) @(negedge clk_sys);
    endtask

    // one-cycle command pulse: 0 start, 1 stop, 2 sweep preset hit
    task automatic pulse(int kind, int s);
        case (kind)
            0: start_cmd[s] = 1'b1;
            1: stop_cmd[s] = 1'b1;
            default: sweep_hit[s] = 1'b1;
        endcase
        cyc(1);
        start_cmd = 4'h0;
        stop_cmd = 4'h0;
        sweep_hit = 4'h0;
        cyc(4);
    endtask

    // gen: modules whose hardware enable the gate line lets through
    task automatic note(logic [3:0] run, logic [7:0] val, logic [7:0] pins,
                        logic [7:0] mask, logic gate, logic [15:0] clr,
                        logic [3:0] gen = 4'hF);
        notes.push_back('{run, val, pins, mask, gate, clr, gen});
        ->seen;
        // hold the stimulus until the watcher has compared this note
        wait (notes.size() == 0);
    endtask

    // watcher: takes the oldest note whenever a result is announced
    initial
    forever
    begin
        @(seen);
        n = notes[0];
        check(16'(acq_running), 16'(n.run));
        check(16'(acq_enable), 16'(n.run & n.gen));
        check(16'(value_out), 16'(n.val));
        check(16'(dig_pin & n.mask), 16'(n.pins & n.mask));
        check(16'(dig_out & n.mask),
              16'(n.pins & n.mask & {8{ctrl_word[`ADGC_CW_PUSHPULL]}}));
        check(16'(gate_oe_n), 16'(n.gate));
        check(16'(gate_in), 16'(n.gate));
        check(clr_cnt - clr_base, n.clr);
        clr_base = clr_cnt;
        notes.delete(0);
    end

    // hang guard at 20000 cycles, well beyond the some 240 cycles the run needs
    initial
    begin
        #(20000 * 50);
        failures++;
        summarize();
    end

    initial
    begin
        reset = 1'b1;
        {start_cmd, stop_cmd, sweep_hit, value_load} = '0;
        {ctrl_word, value_in, trig_pull, mod_sys} = '0;
        mod_en = 4'h3;
        lfsr = 16'h7510;
        cyc(20);
        reset = 1'b0;
        cyc(3);
        note(4'h0, 8'h00, 8'hFF, 8'hFF, 1'b1, 0);
        // status on pins 0..3, every polarity and drive mode
        for (int i = 0; i < 4; i++)
        begin
            ctrl_word = 12'h001 | 12'(i[0]) << 2 | 12'(i[1]) << 3;
            pulse(0, 0);
            note(4'h3, 8'h00, i[0] ? 8'h0C : 8'h03, 8'h0F, 1'b1, 1);
            pulse(1, 0);
            note(4'h0, 8'h00, i[0] ? 8'h0F : 8'h00, 8'h0F, 1'b1, 0);
        end
        // value mode beats status; last pass wraps 255 to 0
        for (int i = 0; i < 4; i++)
        begin
            lfsr = lfsr_next(lfsr);
            v = (i == 3) ? 8'hFF : lfsr[7:0];
            ctrl_word = 12'h003 | 12'(i[0]) << 2 | 12'(i[1]) << 3;
            value_in = v;
            value_load = 1'b1;
            cyc(1);
            value_load = 1'b0;
            cyc(3);
            note(4'h0, v, i[0] ? ~v : v, 8'hFF, 1'b1, 0);
            pulse(0, 0);
            pulse(1, 0);
            v = v + 8'h01;
            note(4'h0, v, i[0] ? ~v : v, 8'hFF, 1'b1, 1);
        end
        // trigger: system 1 on pin 4 clears first, system 2 on pin 5 inverted
        mod_sys[1] = 2'd1;
        for (int s = 0; s < 2; s++)
        begin
            trig_pull[s] = s[0];
            ctrl_word = 12'(s == 0) << `ADGC_CW_CLRSTART
                        | 12'h010 << s | 12'(s[0]) << 2;
            cyc(4);
            pulse(0, s);
            note(4'h0, v, 8'h00, 8'h00, 1'b1, 0);
            for (int k = 0; k < 2; k++)
            begin
                trig_pull[s] = !s[0];
                cyc(6);
                note(4'h1 << s, v, 8'h00, 8'h00, 1'b1,
                     16'(s == 0));
                trig_pull[s] = s[0];
                cyc(6);
                note(4'h0, v, 8'h00, 8'h00, 1'b1, 0);
            end
            pulse(1, s);
            trig_pull[s] = !s[0];
            cyc(6);
            note(4'h0, v, 8'h00, 8'h00, 1'b1, 0);
            trig_pull[s] = s[0];
        end
        // gate line watched: release at start, pull low at sweep preset
        trig_pull = 4'h0;
        mod_en = 4'h1;
        ctrl_word = 12'h700;
        cyc(4);
        pulse(0, 0);
        note(4'h1, v, 8'h00, 8'h00, 1'b1, 1);
        pulse(2, 0);
        note(4'h0, v, 8'h00, 8'h00, 1'b0, 0);
        // without high at start the low gate keeps the hardware disabled
        ctrl_word = 12'h500;
        pulse(0, 0);
        note(4'h1, v, 8'h00, 8'h00, 1'b0, 1, 4'h0);
        pulse(1, 0);
        ctrl_word = 12'h700;
        pulse(0, 0);
        note(4'h1, v, 8'h00, 8'h00, 1'b1, 1);
        pulse(1, 0);
        summarize();
    end
endmodule
